// ===== hdl/seq_pkg.sv
// Constants and carrier types for the frame, bit and word timing sequencer.
// Function
// [R1] Bit counter divides the bit clock by twenty, counts 0 to 19.
// [R2] Bit number is one ahead of count: 19 is bit 0, 14 last, 15 dummy.
// [R3] Word counter steps once per twenty-count bit counter cycle, frame length selectable up to twenty.
// [R4] Word counter advances when the bit counter reaches count 8.
// [R5] Serial shift clock is inverted bit clock, suppressed for counts 16 to 19.
// [R6] Serial output clock suppressed at counts 16 to 18 and whole sync period.
// [R7] Sync period is counts 0-7 of last word plus counts 8-19 of word zero.
// [R8] With a shorter frame, the last word reached replaces word nineteen.
// [R9] Count 16 gives the pulse that loads shift register and forms parity character.
// [R10] Parallel shift clock pulses, in phase with bit clock, at counts 8 and 13.
// [R11] Parallel output clock pulses at counts 3, 8, 13, off during sync.
// [R12] Count 17 of every word gives the converter start pulse.
// [R13] Programmed range comes from a 1-2-4-8 coded switch, code zero unused.
// [R14] Word counter is a decade stage then a divide-by-two stage.
// [R15] On match with the setting the next advance presets the counter to zero.
// [R16] Word advance is a narrow pulse from the fourth stage, not its level.
// [R17] Each word count has a gate, plus five-word group gates.
// [R18] Serial output clock is inverse bit clock gated off by combined inhibit.
// [R19] Select run, time-high, time-low at loads of words 1, 2, 3, else converter.
// [R20] Group gates cover words 0-4, 5-9, 10-14 and 15-19.
// [R21] Both counters synchronous with enables, reset to zero asynchronously.
package seq_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] OFS_FRAME  = 8'h00;
  localparam logic [7:0] OFS_RANGE  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  localparam int UNITS_POS  = 0;
  localparam int TENS_POS   = 4;
  localparam int RMODE_POS  = 4;
  localparam int BITCNT_POS = 0;
  localparam int BITNUM_POS = 8;
  localparam int WORD_POS   = 16;
  localparam int SYNC_POS   = 24;

  localparam logic [3:0] FRAME_UNITS_RST = 4'h9;
  localparam logic [3:0] FRAME_TENS_RST  = 4'h1;
  localparam logic [3:0] RANGE_CODE_RST  = 4'h1;
  localparam logic       RANGE_MODE_RST  = 1'b0;

  // ==========================================================================
  // Counter constants.
  localparam logic [4:0] BIT_LAST   = 5'h13;
  localparam logic [4:0] BIT_ZERO   = 5'h00;
  localparam logic [4:0] C_PAR_A    = 5'h03;
  localparam logic [4:0] C_ADVANCE  = 5'h08;
  localparam logic [4:0] C_PAR_B    = 5'h0d;
  localparam logic [4:0] C_LASTDATA = 5'h0e;
  localparam logic [4:0] C_DUMMY    = 5'h0f;
  localparam logic [4:0] C_LOAD     = 5'h10;
  localparam logic [4:0] C_CONVERT  = 5'h11;
  localparam logic [4:0] C_INH_END  = 5'h12;
  localparam logic [3:0] DECADE_TOP = 4'h9;
  localparam int         WORDS      = 20;
  localparam int         GROUP      = 5;
  localparam int         GROUPS     = 4;

  // ==========================================================================
  // Carrier types.
  typedef enum logic [1:0] {
    SEL_CONVERTER,
    SEL_RUN,
    SEL_TIME_HIGH,
    SEL_TIME_LOW
  } in_sel_e;

  typedef struct packed {
    logic    ser_shift_clk;
    logic    ser_out_clk;
    logic    load_parity_pulse;
    logic    par_shift_clk;
    logic    par_out_clk;
    logic    sync_period;
    in_sel_e in_sel;
  } fmt_s;

  typedef struct packed {
    logic       convert_start_time;
    logic       range_prog;
    logic [3:0] range_sel;
  } adc_s;

endpackage

// ===== hdl/frame_bit_word_sequencer.sv
// Bit and word counters with formatter, converter and multiplexer timing decode.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module frame_bit_word_sequencer (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          bit_clk_pin,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  output var  seq_pkg::fmt_s fmt,
  output var  seq_pkg::adc_s adc,
  output var  logic [19:0]   word_gate,
  output var  logic [3:0]    group_gate
);

  // ==========================================================================
  // Bit clock pin synchroniser and filtered level.
  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       cl;
  logic [4:0] bit_cnt;
  logic       word_hi;
  logic [3:0] word_bcd;
  logic [3:0] frame_units;
  logic [3:0] frame_tens;
  logic [3:0] range_code;
  logic       range_mode;

  wire        agree   = (sync2 == sync3);
  wire        next_cl = agree ? sync3 : cl;
  wire        step    = next_cl & ~cl;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      cl    <= 1'b0;
    end else begin
      sync1 <= bit_clk_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      cl    <= next_cl;
    end
  end

  // ==========================================================================
  // Counters, both stepped by the bit clock edge as an enable.
  // [R1] Divide by twenty.
  wire [4:0]  bit_inc      = 5'(bit_cnt + 5'h01);
  wire [4:0]  next_bit_cnt = !step ? bit_cnt : (bit_cnt == seq_pkg::BIT_LAST) ? seq_pkg::BIT_ZERO : bit_inc;
  // [R4] Advance at count 8.
  // [R16] Single-cycle advance pulse.
  wire        advance      = step & (next_bit_cnt == seq_pkg::C_ADVANCE);
  // [R3] Compare with frame setting.
  // [R8] Setting marks the last word.
  wire        last_word    = (word_hi == frame_tens[0]) && (frame_tens[3:1] == 3'h0) && (word_bcd == frame_units);
  wire        decade_wrap  = (word_bcd == seq_pkg::DECADE_TOP);
  // [R14] Decade then divide-by-two.
  wire [3:0]  bcd_inc      = decade_wrap ? 4'h0 : 4'(word_bcd + 4'h1);
  wire        hi_inc       = decade_wrap ? ~word_hi : word_hi;
  // [R15] Match presets to zero.
  wire [3:0]  next_bcd     = !advance ? word_bcd : last_word ? 4'h0 : bcd_inc;
  wire        next_hi      = !advance ? word_hi : last_word ? 1'b0 : hi_inc;

  // [R21] Synchronous counters, asynchronous zero.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt  <= seq_pkg::BIT_ZERO;
      word_bcd <= 4'h0;
      word_hi  <= 1'b0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      word_bcd <= next_bcd;
      word_hi  <= next_hi;
    end
  end

  // ==========================================================================
  // Bit time decode from next values so that the outputs line up.
  wire        n_ge8      = (next_bit_cnt >= seq_pkg::C_ADVANCE);
  wire        n_top      = next_bit_cnt[4];
  wire        n_load     = (next_bit_cnt == seq_pkg::C_LOAD);
  wire        n_conv     = (next_bit_cnt == seq_pkg::C_CONVERT);
  wire        n_c16_18   = n_top && (next_bit_cnt <= seq_pkg::C_INH_END);
  wire        n_c8_13    = (next_bit_cnt == seq_pkg::C_ADVANCE) || (next_bit_cnt == seq_pkg::C_PAR_B);
  wire        n_c3_8_13  = n_c8_13 || (next_bit_cnt == seq_pkg::C_PAR_A);
  wire        n_last     = (next_hi == frame_tens[0]) && (frame_tens[3:1] == 3'h0) && (next_bcd == frame_units);
  wire        n_w0       = ~next_hi && (next_bcd == 4'h0);
  // [R7] Sync spans last word counts 0-7 and word zero counts 8-19.
  // [R8] Last reached word used in place of nineteen.
  wire        next_sync  = (n_last & ~n_ge8) | (n_w0 & n_ge8);
  // [R6] Combined serial output inhibit.
  wire        ser_inhib  = n_c16_18 | next_sync;

  // [R19] Input register selection per word.
  wire        n_w1       = ~next_hi && (next_bcd == 4'h1);
  wire        n_w2       = ~next_hi && (next_bcd == 4'h2);
  wire        n_w3       = ~next_hi && (next_bcd == 4'h3);
  wire seq_pkg::in_sel_e next_sel = !n_load ? fmt.in_sel :
                                    n_w1 ? seq_pkg::SEL_RUN :
                                    n_w2 ? seq_pkg::SEL_TIME_HIGH :
                                    n_w3 ? seq_pkg::SEL_TIME_LOW : seq_pkg::SEL_CONVERTER;

  seq_pkg::fmt_s next_fmt;
  seq_pkg::adc_s next_adc;
  // [R5] Shift clock off while top stage set.
  assign next_fmt.ser_shift_clk     = ~next_cl & ~n_top;
  // [R18] Inverse bit clock gated by inhibit.
  // [R6] Suppressed at counts 16 to 18 and sync.
  assign next_fmt.ser_out_clk       = ~next_cl & ~ser_inhib;
  // [R9] Load and parity pulse.
  assign next_fmt.load_parity_pulse = n_load;
  // [R10] Parallel shift clock pulses.
  assign next_fmt.par_shift_clk     = next_cl & n_c8_13;
  // [R11] Parallel output clock pulses.
  assign next_fmt.par_out_clk       = next_cl & n_c3_8_13 & ~next_sync;
  assign next_fmt.sync_period       = next_sync;
  assign next_fmt.in_sel            = next_sel;
  // [R12] Conversion start.
  assign next_adc.convert_start_time = n_conv;
  // [R13] Programmed range, code zero unused.
  assign next_adc.range_prog        = range_mode && (range_code != 4'h0);
  assign next_adc.range_sel         = range_mode ? range_code : 4'h0;

  // ==========================================================================
  // Word and group gates.
  logic [19:0] next_gate;
  logic [3:0]  next_group;
  genvar gi;
  generate
    // [R17] Individual word gates.
    for (gi = 0; gi < seq_pkg::WORDS; gi = gi + 1) begin : g_word
      localparam logic       GHI  = (gi >= 10);
      localparam logic [3:0] GBCD = 4'(gi % 10);
      assign next_gate[gi] = (next_hi == GHI) && (next_bcd == GBCD);
    end
    // [R20] Five-word group gates.
    for (gi = 0; gi < seq_pkg::GROUPS; gi = gi + 1) begin : g_group
      assign next_group[gi] = |next_gate[gi*seq_pkg::GROUP +: seq_pkg::GROUP];
    end
  endgenerate

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fmt        <= '0;
      adc        <= '0;
      word_gate  <= 20'h00001;
      group_gate <= 4'h1;
    end else begin
      fmt        <= next_fmt;
      adc        <= next_adc;
      word_gate  <= next_gate;
      group_gate <= next_group;
    end
  end

  // ==========================================================================
  // APB slave, one access cycle, answer at the first access edge.
  wire        setup    = psel & ~penable;
  wire        wr_done  = psel & penable & pready & pwrite;
  wire        hit_fr   = (paddr[31:0] == {24'h0, seq_pkg::OFS_FRAME});
  wire        hit_rg   = (paddr[31:0] == {24'h0, seq_pkg::OFS_RANGE});
  wire        hit_st   = (paddr[31:0] == {24'h0, seq_pkg::OFS_STATUS});
  wire        hit      = hit_fr | hit_rg | hit_st;
  wire [4:0]  bit_num  = (bit_cnt == seq_pkg::BIT_LAST) ? seq_pkg::BIT_ZERO : bit_inc;
  wire [31:0] rd_fr    = {24'h0, frame_tens, frame_units};
  wire [31:0] rd_rg    = {27'h0, range_mode, range_code};
  // [R2] Bit number one ahead of count.
  wire [31:0] rd_st    = {7'h0, fmt.sync_period, 3'h0, word_hi, word_bcd, 3'h0, bit_num, 3'h0, bit_cnt};
  wire [31:0] rd_val   = hit_fr ? rd_fr : hit_rg ? rd_rg : hit_st ? rd_st : 32'h0;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & ~pwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_units <= seq_pkg::FRAME_UNITS_RST;
      frame_tens  <= seq_pkg::FRAME_TENS_RST;
      range_code  <= seq_pkg::RANGE_CODE_RST;
      range_mode  <= seq_pkg::RANGE_MODE_RST;
    end else begin
      if (wr_done && hit_fr) begin
        frame_units <= pwdata[seq_pkg::UNITS_POS +: 4];
        frame_tens  <= pwdata[seq_pkg::TENS_POS +: 4];
      end
      if (wr_done && hit_rg) begin
        range_code <= pwdata[3:0];
        range_mode <= pwdata[seq_pkg::RMODE_POS];
      end
    end
  end

endmodule // frame_bit_word_sequencer
`default_nettype wire

// ===== verif/seq_monitor.sv
// Port assertions for the sequencer.
`timescale 1ns/1ns
`default_nettype none
module seq_monitor (
  input wire logic          core_clk,
  input wire logic          sys_rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire seq_pkg::fmt_s fmt,
  input wire seq_pkg::adc_s adc,
  input wire logic [19:0]   word_gate,
  input wire logic [3:0]    group_gate
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ========================================
  // Properties.
  property p_apb; psel && !penable |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("no answer after setup");
  property p_order; $fell(fmt.load_parity_pulse) |-> adc.convert_start_time; endproperty
  a_order: assert property (p_order) else $error("convert start not after load");
  property p_inh; $fell(adc.convert_start_time) |-> !fmt.ser_shift_clk && !fmt.ser_out_clk; endproperty
  a_inh: assert property (p_inh) else $error("serial clock at count 18");
  property p_ldinh; fmt.load_parity_pulse |-> !fmt.ser_out_clk; endproperty
  a_ldinh: assert property (p_ldinh) else $error("output clock at count 16");
  property p_sync; fmt.sync_period |-> !fmt.ser_out_clk && !fmt.par_out_clk; endproperty
  a_sync: assert property (p_sync) else $error("output clock during sync");
  property p_onehot; $onehot(word_gate); endproperty
  a_onehot: assert property (p_onehot) else $error("word gate not one hot");
  property p_group;
    group_gate == {|word_gate[19:15], |word_gate[14:10], |word_gate[9:5], |word_gate[4:0]};
  endproperty
  a_group: assert property (p_group) else $error("group gate wrong");
  property p_sel; fmt.load_parity_pulse && word_gate[2] |-> fmt.in_sel == seq_pkg::SEL_TIME_HIGH; endproperty
  a_sel: assert property (p_sel) else $error("wrong input select");
  property p_wrap; $rose(word_gate[0]) |-> fmt.sync_period; endproperty
  a_wrap: assert property (p_wrap) else $error("no sync at word zero");
  property p_par; fmt.par_shift_clk |-> fmt.par_out_clk || fmt.sync_period; endproperty
  a_par: assert property (p_par) else $error("shift clock without output clock");
  c_load: cover property (fmt.load_parity_pulse);
  c_sync: cover property (fmt.sync_period);
  c_par: cover property (fmt.par_out_clk);
endmodule // seq_monitor
`default_nettype wire

// ===== verif/bit_clock_source.sv
// Incoming bit clock source, one bit period per request.
`timescale 1ns/1ns
`default_nettype none
module bit_clock_source #(parameter int HALF = 8) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic go,
  output var  logic bit_clk_pin,
  output var  logic done
);
  int t;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      t <= 0;
      bit_clk_pin <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= (t == 2 * HALF);
      if (t == 0 && go) begin
        t <= 1;
        bit_clk_pin <= 1'b1;
      end else if (t != 0) begin
        t <= (t == 2 * HALF) ? 0 : t + 1;
        if (t == HALF) bit_clk_pin <= 1'b0;
      end
    end
  end
endmodule // bit_clock_source
`default_nettype wire

// ===== verif/frame_bit_word_sequencer_test.sv
// Self-checking bench for the sequencer.
`timescale 1ns/1ns
`default_nettype none
module frame_bit_word_sequencer_test;
  logic          core_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic          go = 1'b0;
  logic [31:0]   paddr = 32'h0;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, err, bit_clk_pin, done;
  seq_pkg::fmt_s fmt;
  seq_pkg::adc_s adc;
  logic [19:0]   word_gate;
  logic [3:0]    group_gate;
  int            n_errors = 0, checked = 0, cnt = 0, word = 0, setting = 19, sel = 0;
  always #50 core_clk = ~core_clk;
  frame_bit_word_sequencer i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .bit_clk_pin(bit_clk_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fmt(fmt), .adc(adc), .word_gate(word_gate), .group_gate(group_gate));
  bit_clock_source #(.HALF(8)) i_src (.core_clk(core_clk), .sys_rst(sys_rst), .go(go),
    .bit_clk_pin(bit_clk_pin), .done(done));
  // ========================================
  // Shared tasks.
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_errors++;
      wrap_up;
    end
  endtask
  function automatic logic sync();
    return (word == setting && cnt < 8) || (word == 0 && cnt >= 8);
  endfunction
  task pulse;
    int i;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    cnt = (cnt + 1) % 20;
    if (cnt == 8) word = (word == setting) ? 0 : (word + 1) % 20;
    if (cnt == 16) sel = (word >= 1 && word <= 3) ? word : 0;
    repeat (6) @(posedge core_clk);
    chk("par_shift_clk", fmt.par_shift_clk, cnt == 8 || cnt == 13);
    chk("par_out_clk", fmt.par_out_clk, (cnt == 3 || cnt == 8 || cnt == 13) && !sync());
    chk("ser_shift_high", fmt.ser_shift_clk, 0);
    chk("ser_out_high", fmt.ser_out_clk, 0);
    for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge core_clk);
    if (i == 40) begin
      n_errors++;
      wrap_up;
    end
    chk("ser_shift_clk", fmt.ser_shift_clk, cnt < 16);
    chk("ser_out_clk", fmt.ser_out_clk, !(cnt >= 16 && cnt <= 18) && !sync());
    chk("par_shift_low", fmt.par_shift_clk, 0);
    chk("par_out_low", fmt.par_out_clk, 0);
    chk("load_parity_pulse", fmt.load_parity_pulse, cnt == 16);
    chk("convert_start_time", adc.convert_start_time, cnt == 17);
    chk("sync_period", fmt.sync_period, sync());
    chk("in_sel", fmt.in_sel, sel);
    chk("word_gate", word_gate, 1 << word);
    chk("group_gate", group_gate, 1 << (word / 5));
  endtask
  // ========================================
  // Scenarios.
  task t_reset;
    apb(1'b0, 32'h0, 32'h0);
    chk("frame_reset", rd, 32'h19);
    apb(1'b0, 32'h4, 32'h0);
    chk("range_reset", rd, 32'h1);
    apb(1'b0, 32'h8, 32'h0);
    chk("status_reset", rd, 32'h100);
    apb(1'b0, 32'hc, 32'h0);
    chk("unmapped_rd", rd, 32'h0);
    chk("unmapped_err", err, 1'b1);
    $display("test reset done");
  endtask
  task t_frame(input logic [7:0] s, input int n);
    apb(1'b1, 32'h0, {24'h0, s});
    setting = s[7:4] * 10 + s[3:0];
    repeat (n) pulse;
    apb(1'b0, 32'h8, 32'h0);
    chk("status", rd, cnt | (((cnt + 1) % 20) << 8) | ((word % 10) << 16) | ((word >= 10) << 20)
      | (sync() << 24));
    $display("test frame %h done", s);
  endtask
  task t_range;
    logic [31:0] v[3];
    v = '{32'h15, 32'h10, 32'h05};
    foreach (v[k]) begin
      apb(1'b1, 32'h4, v[k]);
      apb(1'b0, 32'h4, 32'h0);
      chk("range_read", rd, v[k]);
      chk("range_prog", adc.range_prog, v[k][4] && v[k][3:0] != 4'h0);
      chk("range_sel", adc.range_sel, v[k][4] ? v[k][3:0] : 4'h0);
    end
    apb(1'b1, 32'hc, 32'h0);
    chk("unmapped_write_err", err, 1'b1);
    $display("test range done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_frame(8'h19, 420);
    t_frame(8'h03, 100);
    t_frame(8'h00, 370);
    t_frame(8'h12, 300);
    t_range;
    wrap_up;
  end
endmodule // frame_bit_word_sequencer_test
bind frame_bit_word_sequencer seq_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pready(pready), .fmt(fmt), .adc(adc), .word_gate(word_gate), .group_gate(group_gate));
`default_nettype wire
